/* File: verilog/vcr_regs.svh */
// Register offsets, field positions and reset values for the VC resource bank.
// Assumes a byte-addressed configuration access port on the core clock.
`ifndef VCR_REGS_SVH
`define VCR_REGS_SVH
// ************************************************************
// Offsets
// ************************************************************
`define VCR_OFF_VC0_CTL      12'h214
`define VCR_OFF_VC0_STS      12'h218
`define VCR_OFF_VC1_CAP      12'h21C
// ************************************************************
// Field positions
// ************************************************************
`define VCR_CTL_LOAD_BIT     16
`define VCR_CTL_SEL_LO       17
`define VCR_CTL_SEL_HI       19
`define VCR_CTL_ID_LO        24
`define VCR_CTL_ID_HI        26
`define VCR_CTL_EN_BIT       31
`define VCR_STS_TBL_BIT      16
`define VCR_STS_NEG_BIT      17
`define VCR_CAP_ARB_LO       0
`define VCR_CAP_ARB_HI       7
`define VCR_CAP_ADV_BIT      14
`define VCR_CAP_RJS_BIT      15
`define VCR_CAP_MTS_LO       16
`define VCR_CAP_MTS_HI       22
`define VCR_CAP_OFF_LO       24
`define VCR_CAP_OFF_HI       31
// ************************************************************
// Reset values
// ************************************************************
`define VCR_RST_SEL          3'h0
`define VCR_RST_ARB_CAP      8'h01
`define VCR_RST_TBL_OFF      8'h00
`define VCR_VC0_ID           3'h0
`define VCR_VC0_EN           1'h1
`endif

/* File: verilog/vcr_pkg.sv */
// Types for the VC resource register bank.
// Assumes vcr_regs.svh supplies offsets and field positions.
package vcr_pkg;
  // ************************************************************
  // Register access request
  // ************************************************************
  typedef struct packed {
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
    logic [11:0] addr;  // Byte offset of the register
    logic [31:0] wdata; // Write data
  } vcr_req_t;
  // Table load handshake state
  typedef enum logic [1:0] {VCR_IDLE, VCR_WAIT} vcr_load_t;
endpackage : vcr_pkg

/* File: verilog/vcr_bank.sv */
// VC resource 0 control/status and VC1 capability registers of one port.
// Assumes a one-cycle config access port and an external arbiter that
// acknowledges table loads with a one-cycle done pulse.
// Functional notes
// - VC0 channel identifier reads zero, read-only
// - VC0 channel enable reads one, read-only
// - Table entry write sets table status
// - Status clears after hardware finishes table load
// - VC0 negotiation pending always reads zero
// - VC1 capability resets one, lock-writable
// - Capability may hold several scheme bits
// - Advanced switching capability reads zero
// - Reject-snoop capability reads zero
// - Max time slots reads zero
// - Table offset in 16-byte units, lock-writable
// - Table load pulses arbiter, reads zero
`timescale 1ns/1ps
`include "vcr_regs.svh"
module vcr_bank
  import vcr_pkg::*;
(
  input  wire logic        CLK,         // Core clock 50 MHz
  input  wire logic        RESET,       // Synchronous, active high
  input  wire vcr_req_t    REQ,         // Register access request
  input  wire logic        LOCK_OPEN,   // Lock condition allows LOCK_WRITABLE writes
  input  wire logic        TBL_WRITE,   // Software wrote a table entry
  input  wire logic        LOAD_DONE,   // Arbiter finished latching table
  output logic [31:0]      RDATA,       // Read data, registered
  output logic             RVALID,      // Read data valid pulse
  output logic             LOAD_REQ,    // Pulse: arbiter latches table
  output logic [2:0]       ARB_SELECT,  // Selected arbitration scheme
  output logic [7:0]       ARB_CAP,     // Advertised capability
  output logic [7:0]       TBL_OFFSET   // Table offset, 16-byte units
);
  // ************************************************************
  // Decode
  // ************************************************************
  logic wr_ctl;                         // Write to VC0 control
  logic wr_cap;                         // Write to VC1 capability
  assign wr_ctl = REQ.wr && (REQ.addr == `VCR_OFF_VC0_CTL);
  assign wr_cap = REQ.wr && (REQ.addr == `VCR_OFF_VC1_CAP) && LOCK_OPEN;

  logic [2:0] sel_q;                    // Arbitration select
  logic [7:0] cap_q;                    // Capability field
  logic [7:0] off_q;                    // Table offset field
  logic       sts_q;                    // Table status bit
  logic       load_q;                   // Load request pulse
  vcr_load_t  st_q;                     // Load handshake state
  logic       load_set;                 // Software asked for a load
  assign load_set = wr_ctl && REQ.wdata[`VCR_CTL_LOAD_BIT];

  // Select is stored as written; software keeps it legal
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sel_q <= `VCR_RST_SEL;
    end else if (wr_ctl) begin
      sel_q <= REQ.wdata[`VCR_CTL_SEL_HI:`VCR_CTL_SEL_LO];
    end
  end

  // Lock-writable capability and offset fields
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cap_q <= `VCR_RST_ARB_CAP;
      off_q <= `VCR_RST_TBL_OFF;
    end else if (wr_cap) begin
      // All eight bits kept, several schemes may be set
      cap_q <= REQ.wdata[`VCR_CAP_ARB_HI:`VCR_CAP_ARB_LO];
      off_q <= REQ.wdata[`VCR_CAP_OFF_HI:`VCR_CAP_OFF_LO];
    end
  end

  // ************************************************************
  // Table load handshake
  // ************************************************************
  // Load bit is a one-shot; writing zero does nothing
  always_ff @(posedge CLK) begin
    if (RESET) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load_set;
    end
  end

  // Waits for the arbiter after a load request seen in idle; requests during the wait add no wait of their own
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= VCR_IDLE;
    end else begin
      case (st_q)
        VCR_IDLE: begin
          if (load_q) st_q <= VCR_WAIT;
        end
        VCR_WAIT: begin
          if (LOAD_DONE) st_q <= VCR_IDLE;
        end
        default: st_q <= VCR_IDLE;
      endcase
    end
  end

  // Status: a new table write wins over completion of a load
  always_ff @(posedge CLK) begin
    if (RESET) begin
      sts_q <= 1'b0;
    end else if (TBL_WRITE) begin
      sts_q <= 1'b1;
    end else if (st_q == VCR_WAIT && LOAD_DONE) begin
      sts_q <= 1'b0;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] rd_d;                    // Read mux
  always_comb begin
    rd_d = 32'h00000000;                // Reserved bits zero
    case (REQ.addr)
      `VCR_OFF_VC0_CTL: begin
        rd_d[`VCR_CTL_SEL_HI:`VCR_CTL_SEL_LO] = sel_q;
        rd_d[`VCR_CTL_ID_HI:`VCR_CTL_ID_LO]   = `VCR_VC0_ID;
        rd_d[`VCR_CTL_EN_BIT]                 = `VCR_VC0_EN;
        // Load bit left at zero on read
      end
      `VCR_OFF_VC0_STS: begin
        rd_d[`VCR_STS_TBL_BIT] = sts_q;
        rd_d[`VCR_STS_NEG_BIT] = 1'b0;
      end
      `VCR_OFF_VC1_CAP: begin
        rd_d[`VCR_CAP_ARB_HI:`VCR_CAP_ARB_LO] = cap_q;
        rd_d[`VCR_CAP_ADV_BIT] = 1'b0;
        rd_d[`VCR_CAP_RJS_BIT] = 1'b0;
        rd_d[`VCR_CAP_MTS_HI:`VCR_CAP_MTS_LO] = 7'h00;
        rd_d[`VCR_CAP_OFF_HI:`VCR_CAP_OFF_LO] = off_q;
      end
      default: rd_d = 32'h00000000;     // Unmapped reads zero
    endcase
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      RDATA  <= 32'h00000000;
      RVALID <= 1'b0;
    end else begin
      RVALID <= REQ.rd;
      if (REQ.rd) RDATA <= rd_d;
    end
  end

  assign LOAD_REQ   = load_q;
  assign ARB_SELECT = sel_q;
  assign ARB_CAP    = cap_q;
  assign TBL_OFFSET = off_q;

  // ************************************************************
  // Checks
  // ************************************************************
  // Load request follows every load write by exactly one cycle
  a_load_pulse: assert property (
    @(posedge CLK) disable iff (RESET)
    load_set |=> LOAD_REQ)
    else $error("load request missing after load write");
  // No request without a load write, so back-to-back loads stay legal
  a_load_quiet: assert property (
    @(posedge CLK) disable iff (RESET)
    !load_set |=> !LOAD_REQ)
    else $error("load request without load write");
  a_sts_set: assert property (
    @(posedge CLK) disable iff (RESET)
    TBL_WRITE |=> sts_q)
    else $error("table write did not set status");
  a_sts_clr: assert property (
    @(posedge CLK) disable iff (RESET)
    (st_q == VCR_WAIT && LOAD_DONE && !TBL_WRITE) |=> !sts_q)
    else $error("status not cleared after load");
  a_sts_hold: assert property (
    @(posedge CLK) disable iff (RESET)
    (sts_q && !LOAD_DONE) |=> sts_q)
    else $error("status dropped before load done");
  // Fixed identifier, enable and reserved bits of the control word
  a_vc0_ctl: assert property (
    @(posedge CLK) disable iff (RESET)
    (REQ.rd && REQ.addr == `VCR_OFF_VC0_CTL) |=>
    (RDATA[31:20] == 12'h800 && RDATA[16:0] == 17'h00000))
    else $error("vc0 control fixed bits wrong");
  a_vc0_sts: assert property (
    @(posedge CLK) disable iff (RESET)
    (REQ.rd && REQ.addr == `VCR_OFF_VC0_STS) |=>
    (RDATA[31:17] == 15'h0000 && RDATA[16] == $past(sts_q) &&
     RDATA[15:0] == 16'h0000))
    else $error("vc0 status read wrong");
  a_cap_ro: assert property (
    @(posedge CLK) disable iff (RESET)
    (REQ.rd && REQ.addr == `VCR_OFF_VC1_CAP) |=>
    (RDATA[23:8] == 16'h0000))
    else $error("capability read-only bits set");
  a_cap_lock: assert property (
    @(posedge CLK) disable iff (RESET)
    (REQ.wr && !LOCK_OPEN) |=> $stable(cap_q) && $stable(off_q))
    else $error("locked field changed");
  // Open lock takes all eight capability bits and the offset as written
  a_cap_write: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_cap |=>
    (cap_q == $past(REQ.wdata[`VCR_CAP_ARB_HI:`VCR_CAP_ARB_LO]) &&
     off_q == $past(REQ.wdata[`VCR_CAP_OFF_HI:`VCR_CAP_OFF_LO])))
    else $error("capability write not taken");
  a_sel_write: assert property (
    @(posedge CLK) disable iff (RESET)
    wr_ctl |=>
    (ARB_SELECT == $past(REQ.wdata[`VCR_CTL_SEL_HI:`VCR_CTL_SEL_LO])))
    else $error("select write not taken");
  a_unmapped_zero: assert property (
    @(posedge CLK) disable iff (RESET)
    (REQ.rd && REQ.addr != `VCR_OFF_VC0_CTL &&
     REQ.addr != `VCR_OFF_VC0_STS && REQ.addr != `VCR_OFF_VC1_CAP) |=>
    (RDATA == 32'h00000000))
    else $error("unmapped read not zero");
  // Read valid is a one-cycle answer to each read strobe
  a_rvalid_set: assert property (
    @(posedge CLK) disable iff (RESET)
    REQ.rd |=> RVALID)
    else $error("read valid missing");
  a_rvalid_clear: assert property (
    @(posedge CLK) disable iff (RESET)
    !REQ.rd |=> !RVALID)
    else $error("read valid without read");
  // Main scenarios: load round trip, set/clear race, lock open, stray done
  c_load: cover property (@(posedge CLK) disable iff (RESET)
    load_set ##[1:20] (st_q == VCR_WAIT && LOAD_DONE));
  c_race: cover property (@(posedge CLK) disable iff (RESET)
    TBL_WRITE && st_q == VCR_WAIT && LOAD_DONE);
  c_capwr: cover property (@(posedge CLK) disable iff (RESET) wr_cap);
  c_stray_done: cover property (@(posedge CLK) disable iff (RESET)
    LOAD_DONE && st_q == VCR_IDLE);
  c_sts_read: cover property (@(posedge CLK) disable iff (RESET)
    REQ.rd && REQ.addr == `VCR_OFF_VC0_STS && sts_q);
endmodule : vcr_bank

/* File: verif/test_vcr_bank.sv */
// Self-checking bench for the VC resource register bank.
// Assumes the one-cycle config port and pulse handshakes of vcr_bank.
`timescale 1ns/1ps
`include "vcr_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module test_vcr_bank;
  import vcr_pkg::*;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        clk = 1'b0;   // Core clock, 20 ns
  logic        reset = 1'b1; // Held for 10 cycles
  vcr_req_t    req;          // Access request
  logic        lock_open;    // Lock condition
  logic        tbl_write;    // Table entry written
  logic        load_done;    // Arbiter done pulse
  logic [31:0] rdata;        // Read data
  logic        rvalid;       // Read valid
  logic        load_req;     // Load request pulse
  logic [2:0]  arb_select;   // Selected scheme
  logic [7:0]  arb_cap;      // Capability level
  logic [7:0]  tbl_offset;   // Table offset level
  int          num_errors = 0;
  int          compares = 0;
  // Free-running clock
  always #10 clk = ~clk;
  vcr_bank u_vcr_bank (
    .CLK        (clk),
    .RESET      (reset),
    .REQ        (req),
    .LOCK_OPEN  (lock_open),
    .TBL_WRITE  (tbl_write),
    .LOAD_DONE  (load_done),
    .RDATA      (rdata),
    .RVALID     (rvalid),
    .LOAD_REQ   (load_req),
    .ARB_SELECT (arb_select),
    .ARB_CAP    (arb_cap),
    .TBL_OFFSET (tbl_offset)
  );
  // ************************************************************
  // Access tasks
  // ************************************************************
  // Write strobe for one cycle, launched off the sampling edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask : wr
  // Read strobe; the answer is registered, so look one cycle later
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 32'h00000000};
    @(negedge clk);
    req = '0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, exp)
  endtask : rd
  // One-cycle pulse on the done or the table-write input
  task automatic pulse(input logic done);
    @(negedge clk);
    load_done = done;
    tbl_write = ~done;
    @(negedge clk);
    load_done = 1'b0;
    tbl_write = 1'b0;
  endtask : pulse
  // Counts, verdict and end of run
  task automatic results;
    $display("Checks %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // ************************************************************
  // Tests
  // ************************************************************
  // Whole run is under 200 cycles; the watchdog allows 5000
  initial begin
    #(20 * 5000);
    num_errors++;
    results;
  end
  initial begin
    req = '0;
    lock_open = 1'b0;
    tbl_write = 1'b0;
    load_done = 1'b0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    `CHK(arb_cap, `VCR_RST_ARB_CAP)
    `CHK(tbl_offset, `VCR_RST_TBL_OFF)
    `CHK(arb_select, `VCR_RST_SEL)
    rd(12'h214, 32'h8000_0000);
    rd(12'h218, 32'h0000_0000);
    rd(12'h21C, 32'h0000_0001);
    // Capability is dropped while locked, taken while open
    wr(12'h21C, 32'hFFFF_FFFF);
    rd(12'h21C, 32'h0000_0001);
    lock_open = 1'b1;
    wr(12'h21C, 32'hFFFF_FFFF);
    rd(12'h21C, 32'hFF00_00FF);
    `CHK(arb_cap, 8'hFF)
    `CHK(tbl_offset, 8'hFF)
    lock_open = 1'b0;
    wr(12'h21C, 32'h0000_0000);
    rd(12'h21C, 32'hFF00_00FF);
    // Scheme 7 is legal only now that bit 7 is advertised
    wr(12'h214, 32'hFFFE_FFFF);
    `CHK(load_req, 1'b0)
    rd(12'h214, 32'h800E_0000);
    `CHK(arb_select, 3'h7)
    wr(12'h218, 32'hFFFF_FFFF);
    rd(12'h218, 32'h0000_0000);
    rd(12'h300, 32'h0000_0000);
    // Entry write sets status; a done with no load pending is stray
    pulse(1'b0);
    rd(12'h218, 32'h0001_0000);
    pulse(1'b1);
    rd(12'h218, 32'h0001_0000);
    // Load with scheme 7 kept selected, so the table status matters
    wr(12'h214, 32'h000F_0000);
    `CHK(load_req, 1'b1)
    @(negedge clk);
    `CHK(load_req, 1'b0)
    rd(12'h214, 32'h800E_0000);
    rd(12'h218, 32'h0001_0000);
    pulse(1'b1);
    rd(12'h218, 32'h0000_0000);
    // Entry write in the very cycle the load finishes: the set wins
    wr(12'h214, 32'h000F_0000);
    @(negedge clk);
    tbl_write = 1'b1;
    load_done = 1'b1;
    @(negedge clk);
    tbl_write = 1'b0;
    load_done = 1'b0;
    rd(12'h218, 32'h0001_0000);
    // Several scheme bits at once, then a reset in mid-run
    lock_open = 1'b1;
    wr(12'h21C, 32'h5A00_0003);
    lock_open = 1'b0;
    rd(12'h21C, 32'h5A00_0003);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    `CHK(arb_cap, `VCR_RST_ARB_CAP)
    `CHK(tbl_offset, `VCR_RST_TBL_OFF)
    `CHK(arb_select, `VCR_RST_SEL)
    rd(12'h218, 32'h0000_0000);
    rd(12'h21C, 32'h0000_0001);
    results;
  end
endmodule : test_vcr_bank
